/* hdl/cfi_pkg.sv */
// Shared constants and types for the configurable port memory access block
package cfi_pkg;

	// Clock and timing
	localparam int unsigned CLK_HZ            = 25_000_000;
	localparam int unsigned REF_HZ            = 4_000_000;
	localparam int unsigned REF_DIV           = CLK_HZ / REF_HZ;
	localparam int unsigned ACCESS_REF_CYCLES = 9;
	localparam int unsigned DCL_HALF          = 4;
	localparam int unsigned FRAME_SLOTS       = 32;
	localparam int unsigned NPORT             = 4;

	// Register byte offsets
	localparam logic [7:0] OFF_DATA   = 8'h00;
	localparam logic [7:0] OFF_ADDR   = 8'h04;
	localparam logic [7:0] OFF_CTRL   = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0c;
	localparam logic [7:0] OFF_MODE   = 8'h10;
	localparam logic [7:0] OFF_PMODE  = 8'h14;
	localparam logic [7:0] OFF_SUBCH  = 8'h18;

	// Field positions
	localparam int unsigned MODE_STANDBY_BIT = 1;
	localparam int unsigned MODE_DRIVER_BIT  = 3;
	localparam int unsigned PMODE_CSS_BIT    = 2;
	localparam int unsigned CTRL_RW_BIT      = 7;
	localparam int unsigned ADDR_UD_BIT      = 7;
	localparam int unsigned STATUS_BUSY_BIT  = 0;

	// Reset values
	localparam logic [7:0] MODE_RST  = 8'h00;
	localparam logic [7:0] PMODE_RST = 8'h00;
	localparam logic [7:0] SUBCH_RST = 8'h00;
	localparam logic [7:0] DATA_RST  = 8'h00;

	// Slot function codes
	localparam logic [3:0] CODE_UNASSIGNED = 4'h0;
	localparam logic [3:0] CODE_FULL       = 4'h1;

	// Memory target of an access, control register bits 6..5
	typedef enum logic [1:0] {
		TGT_DM_DATA = 2'b00,
		TGT_DM_CODE = 2'b01,
		TGT_CM_DATA = 2'b10,
		TGT_CM_CODE = 2'b11
	} target_t;

	// Configurable port modes
	typedef enum logic [1:0] {
		PM_FIRST  = 2'b00,
		PM_SECOND = 2'b01,
		PM_THIRD  = 2'b10,
		PM_FOURTH = 2'b11
	} port_mode_t;

	// PCM side receive write
	typedef struct packed {
		logic       valid;
		logic [6:0] slot;
		logic [7:0] data;
	} pcm_rx_t;

endpackage

/* hdl/subchannel_lane.sv */
// Subchannel bit placement between a port time slot and a PCM byte
`timescale 1ns/1ps
`default_nettype none
module subchannel_lane (
	input  wire logic [3:0] code,
	input  wire logic [1:0] sc,
	input  wire logic [7:0] src,
	input  wire logic [7:0] rx,
	input  wire logic [7:0] old,
	output logic      [7:0] port_mask,
	output logic      [7:0] tx,
	output logic      [7:0] merged
);
	logic [7:0] base;
	logic [2:0] pcm_lo;
	logic [2:0] port_lo;
	logic [7:0] pcm_mask;

	// Width and PCM position from the code, port position from select
	always_comb begin
		base    = 8'h00;
		pcm_lo  = 3'h0;
		port_lo = 3'h0;
		if (code == cfi_pkg::CODE_FULL) begin
			base = 8'hff;
		end else if (code[3:1] == 3'b001) begin
			base    = 8'h0f;
			pcm_lo  = code[0] ? 3'h4 : 3'h0;
			port_lo = sc[0] ? 3'h0 : 3'h4;
		end else if (code[3:2] == 2'b01) begin
			base    = 8'h03;
			pcm_lo  = {code[1:0], 1'b0};
			port_lo = {~sc, 1'b0};
		end
		pcm_mask = base << pcm_lo;
		if (code[3]) begin
			// Processor and preprocessed slots use the whole byte
			port_mask = 8'hff;
			tx        = src;
			merged    = rx;
		end else begin
			port_mask = base << port_lo;
			tx        = ((src & pcm_mask) >> pcm_lo) << port_lo;
			merged    = (old & ~pcm_mask) |
			            ((((rx & port_mask) >> port_lo) << pcm_lo)
			             & pcm_mask);
		end
	end
endmodule
`default_nettype wire

/* hdl/cfi_subchannel_memory_access.sv */
// Configurable port subchannel placement, drivers and memory access
//
// Overview of operation
// - Per-port 2-bit select places 64k, 32k and 16k channels in a slot
// - Port mode decides which select field governs each port
// - Bandwidth and PCM position from code; port position from select
// - One subchannel per slot; unused bits inactive
// - Standby off: port outputs floated, generated clock and sync stopped
// - Receive and switching continue during standby
// - Standby on: outputs follow control memory, clock and sync driven when the internal clock source is selected
// - Open drain: ones released, unassigned slots send ones
// - Push-pull: zeros and ones driven, unassigned slots floated
// - Control memory: 4-bit code and 8-bit data per slot and direction
// - Code selects switched, preprocessed or processor slot function
// - Data field is pointer, buffer or direct processor byte
// - Data memory: code and data upstream, data only downstream
// - Upstream data memory code enables or floats the PCM slot
// - Memories reached only through data, address and control registers
// - Data register carries the value, but control memory code is written from control bits 3..0; code fields use low 4 bits
// - Address bit 7 picks upstream block, except data memory writes, which always go upstream; bits 6..0 port and slot
// - Control picks memory, field and direction; bit 7 is read/write
// - Control write starts operation and sets busy until done
// - Single access completes within 9.5 reference clock cycles
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module cfi_subchannel_memory_access #(
	parameter int unsigned REF_DIV  = cfi_pkg::REF_DIV,
	parameter int unsigned DCL_HALF = cfi_pkg::DCL_HALF
) (
	input  wire logic                       clk_sys,
	input  wire logic                       arst_n,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [7:0]                 paddr,
	input  wire logic [31:0]                pwdata,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	input  wire logic                       port_data_clock_in,
	output logic                            port_data_clock_out,
	output logic                            port_data_clock_oe,
	input  wire logic                       port_frame_sync_in,
	output logic                            port_frame_sync_out,
	output logic                            port_frame_sync_oe,
	input  wire logic [cfi_pkg::NPORT-1:0]  upstream_input,
	output logic      [cfi_pkg::NPORT-1:0]  downstream_output,
	output logic      [cfi_pkg::NPORT-1:0]  downstream_output_oe,
	input  wire cfi_pkg::pcm_rx_t           pcm_rx,
	input  wire logic [6:0]                 pcm_tx_slot,
	output logic      [7:0]                 pcm_tx_data,
	output logic                            pcm_tx_en
);
	localparam int unsigned NP = cfi_pkg::NPORT;
	localparam logic [7:0] REF_LAST = 8'(REF_DIV - 1);
	localparam logic [3:0] OP_LAST  = 4'(cfi_pkg::ACCESS_REF_CYCLES - 1);
	localparam logic [7:0] DCL_LAST = 8'(DCL_HALF - 1);
	localparam logic [4:0] SLOT_LAST = 5'(cfi_pkg::FRAME_SLOTS - 1);

	typedef struct packed {
		logic [7:0]      data;
		logic [7:0]      addr;
		logic [7:0]      ctrl;
		logic [7:0]      mode;
		logic [7:0]      pmode;
		logic [7:0]      subch;
		logic            busy;
		logic [7:0]      ref_cnt;
		logic [3:0]      op_cnt;
		logic [1:0]      dcl_sync;
		logic [1:0]      fs_sync;
		logic [NP-1:0]   du_s1;
		logic [NP-1:0]   du_s2;
		logic            dcl_prev;
		logic [7:0]      gen_cnt;
		logic            gen_clk;
		logic [2:0]      bitn;
		logic [4:0]      slot;
		logic [NP*8-1:0] shift;
		logic [NP-1:0]   tx_val;
		logic [NP-1:0]   tx_act;
		logic [NP-1:0]   dd_out;
		logic [NP-1:0]   dd_oe;
		logic            dcl_out;
		logic            dcl_oe;
		logic            fs_out;
		logic            fs_oe;
		logic [31:0]     prdata;
		logic            pready;
		logic            pslverr;
		logic [7:0]      pcm_tx_data;
		logic            pcm_tx_en;
	} state_t;

	state_t s_q;
	state_t s_d;

	// Memories: control memory indexed {up, port, slot}
	logic [3:0] cm_code [0:255];
	logic [7:0] cm_data [0:255];
	logic [3:0] dm_code [0:127];
	logic [7:0] dm_up   [0:127];
	logic [7:0] dm_dn   [0:127];

	// Select field governing a physical port for the current port mode
	function automatic logic [1:0] sc_of(input logic [7:0] pm,
		input logic [7:0] sub, input int unsigned p);
		logic [1:0] idx;
		idx = 2'(p);
		case (cfi_pkg::port_mode_t'(pm[1:0]))
			cfi_pkg::PM_SECOND: idx = {1'b0, idx[0]};
			cfi_pkg::PM_THIRD:  idx = 2'b00;
			default:            idx = 2'(p);
		endcase
		return sub[{idx, 1'b0} +: 2];
	endfunction

	logic           setup;
	logic           wr_en;
	logic           ref_tick;
	logic           op_fire;
	logic           rd_op;
	logic           css_ext;
	logic           standby_on;
	logic           open_drain;
	logic           bit_tick;
	logic           frame_mark;
	logic           acc_reg;
	logic [7:0]     mem_rd;
	logic [7:0]     rd_mux;
	logic           mapped;
	cfi_pkg::target_t tgt;
	logic [NP-1:0]  tx_bit;
	logic [NP-1:0]  tx_act;
	logic [7:0]     rx_byte  [NP];
	logic [7:0]     rx_merge [NP];
	logic [7:0]     tx_byte  [NP];
	logic [7:0]     tx_mask  [NP];
	logic [7:0]     dn_ent   [NP];
	logic [7:0]     up_ent   [NP];

	assign setup      = psel & ~penable;
	assign wr_en      = psel & penable & pwrite & s_q.pready & ~s_q.pslverr;
	assign ref_tick   = s_q.ref_cnt == REF_LAST;
	assign op_fire    = s_q.busy & ref_tick & (s_q.op_cnt == OP_LAST);
	assign rd_op      = s_q.ctrl[cfi_pkg::CTRL_RW_BIT];
	assign tgt        = cfi_pkg::target_t'(s_q.ctrl[6:5]);
	assign css_ext    = s_q.pmode[cfi_pkg::PMODE_CSS_BIT];
	assign standby_on = s_q.mode[cfi_pkg::MODE_STANDBY_BIT];
	assign open_drain = s_q.mode[cfi_pkg::MODE_DRIVER_BIT];
	assign bit_tick   = css_ext ? (s_q.dcl_sync[1] & ~s_q.dcl_prev)
	                            : (s_q.gen_cnt == DCL_LAST & ~s_q.gen_clk);
	assign frame_mark = css_ext ? s_q.fs_sync[1]
	                            : (s_q.slot == SLOT_LAST && s_q.bitn == 3'h0);
	assign acc_reg    = paddr == cfi_pkg::OFF_DATA ||
	                    paddr == cfi_pkg::OFF_ADDR ||
	                    paddr == cfi_pkg::OFF_CTRL;

	// Port lanes: downstream send and upstream receive per physical port
	for (genvar p = 0; p < NP; p++) begin : g_port
		logic [7:0] dn_a;
		logic [7:0] up_a;
		logic [3:0] dn_code;
		logic [3:0] up_code;
		logic [7:0] dn_src;
		logic [7:0] up_old;
		logic [7:0] up_mask;
		assign dn_a    = {1'b0, 2'(p), s_q.slot};
		assign up_a    = {1'b1, 2'(p), s_q.slot};
		assign dn_ent[p] = dn_a;
		assign up_ent[p] = up_a;
		assign dn_code = cm_code[dn_a];
		assign up_code = cm_code[up_a];
		// Data field is pointer or direct byte by function
		assign dn_src  = dn_code[3] ? cm_data[dn_a]
		                            : dm_dn[cm_data[dn_a][6:0]];
		assign up_old  = up_code[3] ? cm_data[up_a]
		                            : dm_up[cm_data[up_a][6:0]];
		assign rx_byte[p] = {s_q.shift[p*8 +: 7], s_q.du_s2[p]};
		subchannel_lane u_dn (
			.code      (dn_code),
			.sc        (sc_of(s_q.pmode, s_q.subch, p)),
			.src       (dn_src),
			.rx        (8'h00),
			.old       (8'h00),
			.port_mask (tx_mask[p]),
			.tx        (tx_byte[p]),
			.merged    ()
		);
		subchannel_lane u_up (
			.code      (up_code),
			.sc        (sc_of(s_q.pmode, s_q.subch, p)),
			.src       (8'h00),
			.rx        (rx_byte[p]),
			.old       (up_old),
			.port_mask (up_mask),
			.tx        (),
			.merged    (rx_merge[p])
		);
		assign tx_bit[p] = tx_byte[p][s_q.bitn];
		assign tx_act[p] = tx_mask[p][s_q.bitn];
	end

	// Memory read for the operation in progress
	always_comb begin
		case (tgt)
			cfi_pkg::TGT_DM_DATA: mem_rd = s_q.addr[cfi_pkg::ADDR_UD_BIT]
			                      ? dm_up[s_q.addr[6:0]]
			                      : dm_dn[s_q.addr[6:0]];
			cfi_pkg::TGT_DM_CODE: mem_rd = {4'h0, dm_code[s_q.addr[6:0]]};
			cfi_pkg::TGT_CM_DATA: mem_rd = cm_data[s_q.addr];
			default:              mem_rd = {4'h0, cm_code[s_q.addr]};
		endcase
	end

	// Register read mux
	always_comb begin
		mapped = 1'b1;
		rd_mux = 8'h00;
		case (paddr)
			cfi_pkg::OFF_DATA:   rd_mux = s_q.data;
			cfi_pkg::OFF_ADDR:   rd_mux = s_q.addr;
			cfi_pkg::OFF_CTRL:   rd_mux = s_q.ctrl;
			cfi_pkg::OFF_STATUS: rd_mux = {7'h00, s_q.busy};
			cfi_pkg::OFF_MODE:   rd_mux = s_q.mode;
			cfi_pkg::OFF_PMODE:  rd_mux = s_q.pmode;
			cfi_pkg::OFF_SUBCH:  rd_mux = s_q.subch;
			default:             mapped = 1'b0;
		endcase
	end

	// Next state
	always_comb begin
		s_d = s_q;
		// Bus answers in the first access cycle; no wait states
		s_d.pready  = setup;
		s_d.pslverr = setup & (~mapped | (pwrite & acc_reg & s_q.busy)
		              | (pwrite & paddr == cfi_pkg::OFF_STATUS));
		if (setup) begin
			s_d.prdata = {24'h000000, rd_mux};
		end
		if (wr_en) begin
			case (paddr)
				cfi_pkg::OFF_DATA:  s_d.data  = pwdata[7:0];
				cfi_pkg::OFF_ADDR:  s_d.addr  = pwdata[7:0];
				cfi_pkg::OFF_MODE:  s_d.mode  = pwdata[7:0];
				cfi_pkg::OFF_PMODE: s_d.pmode = pwdata[7:0];
				cfi_pkg::OFF_SUBCH: s_d.subch = pwdata[7:0];
				default: ;
			endcase
			if (paddr == cfi_pkg::OFF_CTRL) begin
				s_d.ctrl   = pwdata[7:0];
				s_d.busy   = 1'b1;
				s_d.op_cnt = 4'h0;
			end
		end
		// Reference clock enable paces memory operations
		s_d.ref_cnt = ref_tick ? 8'h00 : s_q.ref_cnt + 8'h01;
		if (s_q.busy & ref_tick) begin
			s_d.op_cnt = s_q.op_cnt + 4'h1;
		end
		if (op_fire) begin
			s_d.busy = 1'b0;
			if (rd_op) begin
				s_d.data = mem_rd;
			end
		end
		// Link inputs pass two flops before use
		s_d.dcl_sync = {s_q.dcl_sync[0], port_data_clock_in};
		s_d.fs_sync  = {s_q.fs_sync[0], port_frame_sync_in};
		s_d.du_s1    = upstream_input;
		s_d.du_s2    = s_q.du_s1;
		s_d.dcl_prev = s_q.dcl_sync[1];
		// Generated data clock keeps running; only its pin is stopped
		if (s_q.gen_cnt == DCL_LAST) begin
			s_d.gen_cnt = 8'h00;
			s_d.gen_clk = ~s_q.gen_clk;
		end else begin
			s_d.gen_cnt = s_q.gen_cnt + 8'h01;
		end
		// Bit timing runs in standby too, so reception continues
		if (bit_tick) begin
			s_d.tx_val = tx_bit;
			s_d.tx_act = tx_act;
			for (int p = 0; p < NP; p++) begin
				s_d.shift[p*8 +: 8] = rx_byte[p];
			end
			if (frame_mark) begin
				s_d.slot = 5'h00;
				s_d.bitn = 3'h7;
			end else if (s_q.bitn == 3'h0) begin
				s_d.bitn = 3'h7;
				s_d.slot = s_q.slot + 5'h01;
			end else begin
				s_d.bitn = s_q.bitn - 3'h1;
			end
		end
		// Driver style and standby gating of the port pins
		for (int p = 0; p < NP; p++) begin
			if (open_drain) begin
				s_d.dd_out[p] = 1'b0;
				s_d.dd_oe[p]  = standby_on & s_q.tx_act[p]
				                & ~s_q.tx_val[p];
			end else begin
				s_d.dd_out[p] = s_q.tx_val[p];
				s_d.dd_oe[p]  = standby_on & s_q.tx_act[p];
			end
		end
		s_d.dcl_oe  = standby_on & ~css_ext;
		s_d.fs_oe   = standby_on & ~css_ext;
		s_d.dcl_out = standby_on & ~css_ext & s_q.gen_clk;
		s_d.fs_out  = standby_on & ~css_ext & s_q.slot == SLOT_LAST
		              & s_q.bitn == 3'h0;
		// PCM slot send enable from the tristate field
		s_d.pcm_tx_data = dm_up[pcm_tx_slot];
		s_d.pcm_tx_en   = dm_code[pcm_tx_slot]
		                  != cfi_pkg::CODE_UNASSIGNED;
	end

	// State register
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			s_q       <= '0;
			s_q.data  <= cfi_pkg::DATA_RST;
			s_q.mode  <= cfi_pkg::MODE_RST;
			s_q.pmode <= cfi_pkg::PMODE_RST;
			s_q.subch <= cfi_pkg::SUBCH_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// Memory writes: bus operation, link receive, PCM receive
	always_ff @(posedge clk_sys) begin
		if (op_fire & ~rd_op) begin
			case (tgt)
				cfi_pkg::TGT_DM_DATA: dm_up[s_q.addr[6:0]] <= s_q.data;
				cfi_pkg::TGT_DM_CODE:
					dm_code[s_q.addr[6:0]] <= s_q.data[3:0];
				cfi_pkg::TGT_CM_DATA: cm_data[s_q.addr] <= s_q.data;
				default: cm_code[s_q.addr] <= s_q.ctrl[3:0];
			endcase
		end
		// Last bit of a slot stores the received byte by function
		if (bit_tick && s_q.bitn == 3'h0) begin
			for (int p = 0; p < NP; p++) begin
				if (cm_code[up_ent[p]][3]) begin
					cm_data[up_ent[p]] <= rx_merge[p];
				end else if (cm_code[up_ent[p]] != cfi_pkg::CODE_UNASSIGNED)
				begin
					dm_up[cm_data[up_ent[p]][6:0]] <= rx_merge[p];
				end
			end
		end
		if (pcm_rx.valid) begin
			dm_dn[pcm_rx.slot] <= pcm_rx.data;
		end
	end

	assign prdata               = s_q.prdata;
	assign pready               = s_q.pready;
	assign pslverr              = s_q.pslverr;
	assign downstream_output    = s_q.dd_out;
	assign downstream_output_oe = s_q.dd_oe;
	assign port_data_clock_out  = s_q.dcl_out;
	assign port_data_clock_oe   = s_q.dcl_oe;
	assign port_frame_sync_out  = s_q.fs_out;
	assign port_frame_sync_oe   = s_q.fs_oe;
	assign pcm_tx_data          = s_q.pcm_tx_data;
	assign pcm_tx_en            = s_q.pcm_tx_en;

	// Checks
	logic [7:0] busy_len;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			busy_len <= 8'h00;
		end else begin
			busy_len <= s_q.busy ? busy_len + 8'h01 : 8'h00;
		end
	end

	property p_busy_start;
		@(posedge clk_sys) disable iff (!arst_n)
		(wr_en && paddr == cfi_pkg::OFF_CTRL) |=> s_q.busy;
	endproperty
	a_busy_start: assert property (p_busy_start) else $error("busy not set");

	property p_busy_bound;
		@(posedge clk_sys) disable iff (!arst_n)
		busy_len <= 8'(REF_DIV * cfi_pkg::ACCESS_REF_CYCLES);
	endproperty
	a_busy_bound: assert property (p_busy_bound) else $error("op too long");

	property p_refuse;
		@(posedge clk_sys) disable iff (!arst_n)
		(setup && pwrite && acc_reg && s_q.busy) |=> (pready && pslverr);
	endproperty
	a_refuse: assert property (p_refuse) else $error("busy write taken");

	property p_standby_off;
		@(posedge clk_sys) disable iff (!arst_n)
		!standby_on |=> (downstream_output_oe == '0 && !port_data_clock_oe
		                 && !port_data_clock_out && !port_frame_sync_oe);
	endproperty
	a_standby_off: assert property (p_standby_off) else $error("standby drive");

	property p_clock_on;
		@(posedge clk_sys) disable iff (!arst_n)
		(standby_on && !css_ext) |=> port_data_clock_oe && port_frame_sync_oe;
	endproperty
	a_clock_on: assert property (p_clock_on) else $error("clock not driven");

	property p_open_drain;
		@(posedge clk_sys) disable iff (!arst_n)
		open_drain |=> downstream_output == '0;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("od drives one");

	property p_push_pull;
		@(posedge clk_sys) disable iff (!arst_n)
		(!open_drain && standby_on) |=>
		downstream_output_oe == $past(s_q.tx_act);
	endproperty
	a_push_pull: assert property (p_push_pull) else $error("pp enable wrong");

	property p_code_read;
		@(posedge clk_sys) disable iff (!arst_n)
		(op_fire && rd_op && tgt == cfi_pkg::TGT_CM_CODE)
		|=> s_q.data[7:4] == 4'h0 && !s_q.busy;
	endproperty
	a_code_read: assert property (p_code_read) else $error("code read wide");

	property p_mirror;
		@(posedge clk_sys) disable iff (!arst_n)
		s_q.pmode[1:0] == 2'b10 |->
		sc_of(s_q.pmode, s_q.subch, 3) == s_q.subch[1:0];
	endproperty
	a_mirror: assert property (p_mirror) else $error("select not mirrored");

	property p_width16;
		@(posedge clk_sys) disable iff (!arst_n)
		(cm_code[dn_ent[2]][3:2] == 2'b01) |-> $countones(tx_mask[2]) == 2;
	endproperty
	a_width16: assert property (p_width16) else $error("16k width wrong");

	c_read_op: cover property (@(posedge clk_sys) op_fire && rd_op);
	c_write_op: cover property (@(posedge clk_sys) op_fire && !rd_op);
	c_frame: cover property (@(posedge clk_sys) bit_tick && frame_mark);
	c_refused: cover property (@(posedge clk_sys) s_q.pslverr && s_q.busy);
endmodule
`default_nettype wire

/* sim/serial_partner.sv */
// Serial line device model driving clock, sync and data into the port
`timescale 1ns/1ps
`default_nettype none
module serial_partner #(
	parameter logic [7:0] PATTERN = 8'ha5
) (
	output logic       dclk,
	output logic       fsync,
	output logic [3:0] dout
);
	int unsigned bit_n;

	// Line clock runs free, as a line clock does between frames too
	initial begin
		dclk = 1'b0;
		forever #160 dclk = ~dclk;
	end

	// Change on falling edge so the device samples settled data
	initial begin
		bit_n = 0;
		fsync = 1'b0;
		dout  = 4'hf;
		forever begin
			@(negedge dclk);
			bit_n = (bit_n + 1) % 256;
			fsync <= (bit_n == 255);  // Marks the last bit of a frame
			dout  <= {3'b111, PATTERN[7 - bit_n % 8]};  // MSB first
		end
	end
endmodule
`default_nettype wire

/* sim/tb_top.sv */
// Self-checking bench for the port memory access block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int RDIV  = 2;
	localparam int DHALF = 2;
	localparam int FRAME = 256 * 2 * DHALF;
	logic             clk_sys, arst_n, psel, penable, pwrite;
	logic [7:0]       paddr;
	logic [31:0]      pwdata, prdata;
	logic             pready, pslverr, dclk_o, dclk_oe, fs_o, fs_oe;
	logic             dclk_i, fs_i;
	logic [3:0]       up_in, dn, dn_oe;
	logic [7:0]       tx_data, q;
	logic             tx_en;
	cfi_pkg::pcm_rx_t pcm_rx;
	int               mismatches, n_checks, cyc;

	cfi_subchannel_memory_access #(.REF_DIV(RDIV), .DCL_HALF(DHALF)) dut_u (
		.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .port_data_clock_in(dclk_i),
		.port_data_clock_out(dclk_o), .port_data_clock_oe(dclk_oe),
		.port_frame_sync_in(fs_i), .port_frame_sync_out(fs_o),
		.port_frame_sync_oe(fs_oe), .upstream_input(up_in),
		.downstream_output(dn), .downstream_output_oe(dn_oe),
		.pcm_rx(pcm_rx), .pcm_tx_slot(7'h00), .pcm_tx_data(tx_data),
		.pcm_tx_en(tx_en));
	serial_partner partner_u (.dclk(dclk_i), .fsync(fs_i), .dout(up_in));

	// 25 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	// Cycle count doubles as the hang guard
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			mismatches++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic ok, input string m);
		n_checks++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask

	// One APB transfer, then one idle edge so no signal is set twice
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d, output logic [31:0] r, output logic e);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		// Only the global cycle guard ends a wait for the answer
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask

	// Indirect access: data, address, control, then poll busy
	task automatic mem(input logic [7:0] c, a, d, output logic [7:0] v);
		logic [31:0] r;
		logic        e;
		int          t0, n;
		apb(1'b1, cfi_pkg::OFF_DATA, {24'h0, d}, r, e);
		apb(1'b1, cfi_pkg::OFF_ADDR, {24'h0, a}, r, e);
		apb(1'b1, cfi_pkg::OFF_CTRL, {24'h0, c}, r, e);
		t0 = cyc;
		apb(1'b1, cfi_pkg::OFF_DATA, 32'h0000_0055, r, e);
		chk(e === 1'b1, "write while busy taken");
		n = 0;
		do begin
			apb(1'b0, cfi_pkg::OFF_STATUS, 32'h0, r, e);
			n++;
		end while (r[0] !== 1'b0);
		chk(n > 1, "busy not seen");
		chk(cyc - t0 <= 10 * RDIV + 9, "access too slow");
		apb(1'b0, cfi_pkg::OFF_DATA, 32'h0, r, e);
		v = r[7:0];
	endtask

	// Counts driven cycles of one pin over a whole internal frame
	task automatic count(input int p, output int on, output int hi);
		on = 0;
		hi = 0;
		repeat (FRAME) begin
			@(posedge clk_sys);
			on += (dn_oe[p] === 1'b1);
			hi += (dn_oe[p] === 1'b1 && dn[p] === 1'b1);
		end
	endtask

	task automatic t_regs();
		logic [31:0] r;
		logic        e;
		apb(1'b0, cfi_pkg::OFF_MODE, 32'h0, r, e);
		chk(r === 32'h0, "mode reset");
		apb(1'b0, cfi_pkg::OFF_SUBCH, 32'h0, r, e);
		chk(r === 32'h0, "subchannel reset");
		apb(1'b0, 8'h1c, 32'h0, r, e);
		chk(e === 1'b1 && r === 32'h0, "unmapped read");
		apb(1'b1, cfi_pkg::OFF_STATUS, 32'h1, r, e);
		chk(e === 1'b1, "status write");
		$display("test regs done");
	endtask

	task automatic t_mem();
		for (int i = 0; i < 128; i++) mem(8'h60, i[7:0], 8'h00, q);
		mem(8'h40, 8'h00, 8'h0f, q);
		mem(8'h68, 8'h00, 8'h00, q);
		mem(8'h40, 8'h80, 8'hf3, q);
		mem(8'h60, 8'h80, 8'h00, q);  // Unassigned, so receive leaves it
		mem(8'he0, 8'h00, 8'h00, q);
		chk(q === 8'h08, "code read");
		mem(8'hc0, 8'h00, 8'h00, q);
		chk(q === 8'h0f, "data read down");
		mem(8'hc0, 8'h80, 8'h00, q);
		chk(q === 8'hf3, "data read up");
		mem(8'h20, 8'h03, 8'hf5, q);
		mem(8'ha0, 8'h03, 8'h00, q);
		chk(q === 8'h05, "tristate code read");
		pcm_rx <= '{1'b1, 7'h05, 8'h7c};
		@(posedge clk_sys);
		pcm_rx <= '0;
		mem(8'h80, 8'h05, 8'h00, q);
		chk(q === 8'h7c, "pcm receive read");
		mem(8'h40, 8'h41, 8'h05, q);
		mem(8'h67, 8'h41, 8'h00, q);
		mem(8'h00, 8'h00, 8'h5a, q);
		mem(8'h20, 8'h00, 8'h01, q);
		chk(tx_en === 1'b1 && tx_data === 8'h5a, "pcm slot send");
		mem(8'h20, 8'h00, 8'h00, q);
		chk(tx_en === 1'b0, "pcm slot float");
		$display("test mem done");
	endtask

	task automatic t_drive();
		logic [31:0] r;
		logic        e;
		int          on, hi;
		// Port 0 field stays 00; port 2 takes bits 5..4
		apb(1'b1, cfi_pkg::OFF_SUBCH, 32'h10, r, e);
		count(0, on, hi);
		chk(on == 0 && dclk_oe === 1'b0 && fs_oe === 1'b0, "standby drives");
		apb(1'b1, cfi_pkg::OFF_MODE, 32'h02, r, e);
		count(0, on, hi);
		chk(on == 8 * 2 * DHALF, "push-pull slot");
		chk(dclk_oe === 1'b1 && fs_oe === 1'b1, "clock not driven");
		count(1, on, hi);
		chk(on == 0, "unassigned driven");
		count(2, on, hi);
		chk(on == 4 * DHALF && hi == 2 * DHALF, "16k placement");
		apb(1'b1, cfi_pkg::OFF_MODE, 32'h0a, r, e);
		count(0, on, hi);
		chk(on == 4 * 2 * DHALF && hi == 0, "open drain");
		$display("test drive done");
	endtask

	task automatic t_rx();
		logic [31:0] r;
		logic        e;
		int          on, hi;
		apb(1'b1, cfi_pkg::OFF_MODE, 32'h00, r, e);
		apb(1'b1, cfi_pkg::OFF_PMODE, 32'h04, r, e);
		mem(8'h68, 8'h80, 8'h00, q);
		count(0, on, hi);
		chk(on == 0 && dclk_oe === 1'b0, "standby outputs");
		repeat (4 * FRAME) @(posedge clk_sys);
		mem(8'hc0, 8'h80, 8'h00, q);
		chk(q === 8'ha5, "receive in standby");
		$display("test rx done");
	endtask

	initial begin
		arst_n     = 1'b0;
		psel       = 1'b0;
		penable    = 1'b0;
		pwrite     = 1'b0;
		paddr      = 8'h00;
		pwdata     = 32'h0;
		pcm_rx     = '0;
		mismatches = 0;
		n_checks   = 0;
		cyc        = 0;
		repeat (6) @(posedge clk_sys);
		arst_n <= 1'b1;
		@(posedge clk_sys);
		t_regs();
		t_mem();
		t_drive();
		t_rx();
		end_of_test();
	end
endmodule
`default_nettype wire
